// ---- hdl/tapw_top.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module tapw_top
    import tapw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tapw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tapw_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tapw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tapw_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_timer_input_pin,
    input wire logic slave_timer_input_pin,
    output logic pwm_output_pin,
    output logic master_timer_interrupt,
    output logic slave_timer_interrupt
);
    import tapw_pkg::*;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic div_tick(input logic [CNT_W-1:0] cnt, input logic [3:0] expo);
        logic [CNT_W-1:0] low_mask;
        low_mask = ~({CNT_W{1'b1}} << expo);
        div_tick = &(cnt | ~low_mask);
    endfunction : div_tick

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0])
        begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            merge16[15:8] = data[15:8];
        end
    endfunction : merge16

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] b_resp;
    logic b_valid;
    logic [DATA_W-1:0] r_data;
    logic [1:0] r_resp;
    logic r_valid;
    logic next_aw_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic next_w_held;
    logic [DATA_W-1:0] next_w_data;
    logic [3:0] next_w_strb;
    logic [1:0] next_b_resp;
    logic next_b_valid;
    logic [DATA_W-1:0] next_r_data;
    logic [1:0] next_r_resp;
    logic next_r_valid;

    logic clock_gate;
    logic [15:0] prescale_sel;
    logic [15:0] mode_cfg [2];
    logic [CNT_W-1:0] data_val [2];
    logic [1:0] irq_mask;
    logic next_clock_gate;
    logic [15:0] next_prescale_sel;
    logic [15:0] next_mode_cfg [2];
    logic [CNT_W-1:0] next_data_val [2];
    logic [1:0] next_irq_mask;

    logic [NUM_CH-1:0] count_en;
    logic [1:0] half_en;
    logic [CNT_W-1:0] counter [2];
    tapw_run_t run_state [2];
    logic [1:0] chan_out;
    logic [1:0] chan_irq;
    logic [CNT_W-1:0] prescale_cnt;
    logic [1:0] pin_prev;
    logic [NUM_CH-1:0] next_count_en;
    logic [1:0] next_half_en;
    logic [CNT_W-1:0] next_counter [2];
    tapw_run_t next_run_state [2];
    logic [1:0] next_chan_out;
    logic [1:0] next_chan_irq;
    logic [CNT_W-1:0] next_prescale_cnt;

    logic wr_fire;
    logic [15:0] start_pulse;
    logic [15:0] stop_pulse;
    logic [3:0] op_tick;
    logic [1:0] pin_now;

    assign pin_now = {slave_timer_input_pin, master_timer_input_pin};
    assign s_axi_awready = !aw_held && !b_valid;
    assign s_axi_wready = !w_held && !b_valid;
    assign s_axi_arready = !r_valid;
    assign s_axi_bresp = b_resp;
    assign s_axi_bvalid = b_valid;
    assign s_axi_rdata = r_data;
    assign s_axi_rresp = r_resp;
    assign s_axi_rvalid = r_valid;
    assign pwm_output_pin = chan_out[1];
    assign master_timer_interrupt = chan_irq[0] && !irq_mask[0];
    assign slave_timer_interrupt = chan_irq[1] && !irq_mask[1];

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_b_resp = b_resp;
        next_b_valid = b_valid;
        next_r_data = r_data;
        next_r_resp = r_resp;
        next_r_valid = r_valid;
        wr_fire = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held)
        begin
            wr_fire = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_b_valid = 1'b1;
            if (aw_addr == OFS_START || aw_addr == OFS_CLKGATE || aw_addr == OFS_PRESCALE
                || aw_addr == OFS_MODE0 || aw_addr == OFS_MODE3 || aw_addr == OFS_RELOAD
                || aw_addr == OFS_WIDTH || aw_addr == OFS_STOP || aw_addr == OFS_MASK)
            begin
                next_b_resp = RESP_OKAY;
            end
            else
            begin
                next_b_resp = RESP_SLVERR;
            end
        end
        if (b_valid && s_axi_bready)
        begin
            next_b_valid = 1'b0;
        end
        if (r_valid && s_axi_rready)
        begin
            next_r_valid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_r_valid = 1'b1;
            next_r_resp = RESP_OKAY;
            next_r_data = '0;
            if (s_axi_araddr == OFS_START || s_axi_araddr == OFS_STOP)
            begin
                next_r_data = '0;
            end
            else if (s_axi_araddr == OFS_CLKGATE)
            begin
                next_r_data[GATE_BIT] = clock_gate;
            end
            else if (s_axi_araddr == OFS_PRESCALE)
            begin
                next_r_data[15:0] = prescale_sel;
            end
            else if (s_axi_araddr == OFS_MODE0)
            begin
                next_r_data[15:0] = mode_cfg[0];
            end
            else if (s_axi_araddr == OFS_MODE3)
            begin
                next_r_data[15:0] = mode_cfg[1];
            end
            else if (s_axi_araddr == OFS_RELOAD)
            begin
                next_r_data[15:0] = data_val[0];
            end
            else if (s_axi_araddr == OFS_WIDTH)
            begin
                next_r_data[15:0] = data_val[1];
            end
            else if (s_axi_araddr == OFS_STATUS)
            begin
                next_r_data[NUM_CH-1:0] = count_en;
                next_r_data[ST_RUN0_BIT] = (run_state[0] == TAPW_RUN);
                next_r_data[ST_RUN3_BIT] = (run_state[1] == TAPW_RUN);
                next_r_data[ST_OUT_BIT] = chan_out[1];
                next_r_data[ST_HI_LSB+1:ST_HI_LSB] = half_en;
            end
            else if (s_axi_araddr == OFS_COUNT)
            begin
                next_r_data[15:0] = counter[0];
                next_r_data[COUNT_SLAVE_LSB+15:COUNT_SLAVE_LSB] = counter[1];
            end
            else if (s_axi_araddr == OFS_MASK)
            begin
                next_r_data[1:0] = irq_mask;
            end
            else
            begin
                next_r_resp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            b_resp <= RESP_OKAY;
            b_valid <= 1'b0;
            r_data <= '0;
            r_resp <= RESP_OKAY;
            r_valid <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            b_resp <= next_b_resp;
            b_valid <= next_b_valid;
            r_data <= next_r_data;
            r_resp <= next_r_resp;
            r_valid <= next_r_valid;
        end
    end

    // --------------------------------------------------------------
    // configuration registers
    // --------------------------------------------------------------
    always_comb
    begin
        next_clock_gate = clock_gate;
        next_prescale_sel = prescale_sel;
        next_mode_cfg = mode_cfg;
        next_data_val = data_val;
        next_irq_mask = irq_mask;
        start_pulse = '0;
        stop_pulse = '0;
        if (wr_fire)
        begin
            if (aw_addr == OFS_START)
            begin
                start_pulse = merge16(16'h0000, w_data, w_strb);
            end
            else if (aw_addr == OFS_STOP)
            begin
                stop_pulse = merge16(16'h0000, w_data, w_strb);
            end
            else if (aw_addr == OFS_CLKGATE)
            begin
                if (w_strb[0])
                begin
                    next_clock_gate = w_data[GATE_BIT];
                end
            end
            else if (aw_addr == OFS_PRESCALE)
            begin
                next_prescale_sel = merge16(prescale_sel, w_data, w_strb);
            end
            else if (aw_addr == OFS_MODE0)
            begin
                next_mode_cfg[0] = merge16(mode_cfg[0], w_data, w_strb);
            end
            else if (aw_addr == OFS_MODE3)
            begin
                next_mode_cfg[1] = merge16(mode_cfg[1], w_data, w_strb);
            end
            else if (aw_addr == OFS_RELOAD)
            begin
                next_data_val[0] = merge16(data_val[0], w_data, w_strb);
            end
            else if (aw_addr == OFS_WIDTH)
            begin
                next_data_val[1] = merge16(data_val[1], w_data, w_strb);
            end
            else if (aw_addr == OFS_MASK)
            begin
                if (w_strb[0])
                begin
                    next_irq_mask = w_data[1:0];
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clock_gate <= 1'b0;
            prescale_sel <= RST_REG16;
            mode_cfg[0] <= RST_REG16;
            mode_cfg[1] <= RST_REG16;
            data_val[0] <= RST_REG16;
            data_val[1] <= RST_REG16;
            irq_mask <= RST_MASK;
        end
        else
        begin
            clock_gate <= next_clock_gate;
            prescale_sel <= next_prescale_sel;
            mode_cfg <= next_mode_cfg;
            data_val <= next_data_val;
            irq_mask <= next_irq_mask;
        end
    end

    // --------------------------------------------------------------
    // prescaler and channel engines
    // --------------------------------------------------------------
    always_comb
    begin
        logic [1:0] cks;
        logic [2:0] sts;
        logic [2:0] md;
        logic [1:0] cis;
        logic edge_hit;
        logic cnt_tick;
        logic trig;
        cks = '0;
        sts = '0;
        md = '0;
        cis = '0;
        edge_hit = 1'b0;
        cnt_tick = 1'b0;
        trig = 1'b0;
        next_count_en = (count_en | start_pulse[NUM_CH-1:0]) & ~stop_pulse[NUM_CH-1:0];
        next_half_en[0] = (half_en[0] || start_pulse[START_CH1_HI_BIT]) && !stop_pulse[START_CH1_HI_BIT];
        next_half_en[1] = (half_en[1] || start_pulse[START_SLAVE_HI_BIT])
                          && !stop_pulse[START_SLAVE_HI_BIT];
        next_counter = counter;
        next_run_state = run_state;
        next_chan_out = chan_out;
        next_chan_irq = '0;
        next_prescale_cnt = clock_gate ? prescale_cnt + 16'h0001 : prescale_cnt;
        op_tick[0] = clock_gate && div_tick(prescale_cnt, prescale_sel[PRS_A_LSB+3:PRS_A_LSB]);
        op_tick[1] = clock_gate && div_tick(prescale_cnt, prescale_sel[PRS_B_LSB+3:PRS_B_LSB]);
        op_tick[2] = clock_gate && div_tick(prescale_cnt, {2'h0, prescale_sel[PRS_C_LSB+1:PRS_C_LSB]});
        op_tick[3] = clock_gate && div_tick(prescale_cnt, {2'h0, prescale_sel[PRS_D_LSB+1:PRS_D_LSB]});
        for (int i = 0; i < 2; i++)
        begin
            cks = mode_cfg[i][CKS_LSB+1:CKS_LSB];
            sts = mode_cfg[i][STS_LSB+2:STS_LSB];
            md = mode_cfg[i][MD_LSB+3:MD_LSB+1];
            cis = mode_cfg[i][CIS_LSB+1:CIS_LSB];
            if (cis == CIS_FALL)
            begin
                edge_hit = pin_prev[i] && !pin_now[i];
            end
            else if (cis == CIS_RISE)
            begin
                edge_hit = !pin_prev[i] && pin_now[i];
            end
            else
            begin
                edge_hit = pin_prev[i] != pin_now[i];
            end
            if (mode_cfg[i][CCS_BIT])
            begin
                cnt_tick = clock_gate && edge_hit;
            end
            else
            begin
                case (cks)
                    CKS_A: cnt_tick = op_tick[0];
                    CKS_B: cnt_tick = op_tick[1];
                    CKS_C: cnt_tick = op_tick[2];
                    default: cnt_tick = op_tick[3];
                endcase
            end
            // start trigger source of a one-count channel
            if (sts == STS_MASTER && i == 1)
            begin
                trig = next_chan_irq[0];
            end
            else if (sts == STS_EDGE || sts == STS_BOTH)
            begin
                trig = clock_gate && (sts == STS_BOTH ? pin_prev[i] != pin_now[i] : edge_hit);
            end
            else
            begin
                trig = start_pulse[i == 0 ? MASTER_CH : SLAVE_CH];
            end
            if (!clock_gate || !count_en[i == 0 ? MASTER_CH : SLAVE_CH]
                || stop_pulse[i == 0 ? MASTER_CH : SLAVE_CH])
            begin
                trig = 1'b0;
                cnt_tick = 1'b0;
                if (stop_pulse[i == 0 ? MASTER_CH : SLAVE_CH])
                begin
                    next_run_state[i] = TAPW_IDLE;
                end
            end
            if (md == MD_INTERVAL)
            begin
                if (start_pulse[i == 0 ? MASTER_CH : SLAVE_CH] && clock_gate)
                begin
                    next_counter[i] = data_val[i];
                    next_run_state[i] = TAPW_RUN;
                    if (mode_cfg[i][MD_LSB])
                    begin
                        next_chan_irq[i] = 1'b1;
                        next_chan_out[i] = !chan_out[i];
                    end
                end
                else if (run_state[i] == TAPW_RUN && cnt_tick)
                begin
                    if (counter[i] == '0)
                    begin
                        next_counter[i] = data_val[i];
                        next_chan_irq[i] = 1'b1;
                        next_chan_out[i] = !chan_out[i];
                    end
                    else
                    begin
                        next_counter[i] = counter[i] - 16'h0001;
                    end
                end
            end
            else if (md == MD_ONECOUNT)
            begin
                if (trig && (run_state[i] == TAPW_IDLE || mode_cfg[i][MD_LSB]))
                begin
                    next_counter[i] = data_val[i];
                    next_run_state[i] = (data_val[i] == '0) ? TAPW_IDLE : TAPW_RUN;
                    next_chan_out[i] = (data_val[i] != '0);
                end
                else if (run_state[i] == TAPW_RUN && cnt_tick)
                begin
                    next_counter[i] = counter[i] - 16'h0001;
                    if (counter[i] <= 16'h0001)
                    begin
                        next_counter[i] = '0;
                        next_run_state[i] = TAPW_IDLE;
                        next_chan_out[i] = 1'b0;
                        next_chan_irq[i] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_en <= '0;
            half_en <= '0;
            counter[0] <= RST_REG16;
            counter[1] <= RST_REG16;
            run_state[0] <= TAPW_IDLE;
            run_state[1] <= TAPW_IDLE;
            chan_out <= '0;
            chan_irq <= '0;
            prescale_cnt <= RST_REG16;
            pin_prev <= '0;
        end
        else
        begin
            count_en <= next_count_en;
            half_en <= next_half_en;
            counter <= next_counter;
            run_state <= next_run_state;
            chan_out <= next_chan_out;
            chan_irq <= next_chan_irq;
            prescale_cnt <= next_prescale_cnt;
            pin_prev <= pin_now;
        end
    end

endmodule : tapw_top

// ---- pkg/tapw_pkg.sv ----
package tapw_pkg;

    // --------------------------------------------------------------
    // widths and channel map
    // --------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned MASTER_CH = 0;
    localparam int unsigned SLAVE_CH = 3;

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_START = 8'h00;
    localparam logic [7:0] OFS_CLKGATE = 8'h04;
    localparam logic [7:0] OFS_PRESCALE = 8'h08;
    localparam logic [7:0] OFS_MODE0 = 8'h0C;
    localparam logic [7:0] OFS_MODE3 = 8'h10;
    localparam logic [7:0] OFS_RELOAD = 8'h14;
    localparam logic [7:0] OFS_WIDTH = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_STOP = 8'h20;
    localparam logic [7:0] OFS_COUNT = 8'h24;
    localparam logic [7:0] OFS_MASK = 8'h28;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int unsigned START_SLAVE_HI_BIT = 11;
    localparam int unsigned START_CH1_HI_BIT = 9;
    localparam int unsigned GATE_BIT = 0;
    localparam int unsigned PRS_A_LSB = 0;
    localparam int unsigned PRS_B_LSB = 4;
    localparam int unsigned PRS_C_LSB = 8;
    localparam int unsigned PRS_D_LSB = 12;
    localparam int unsigned CKS_LSB = 14;
    localparam int unsigned CCS_BIT = 12;
    localparam int unsigned STS_LSB = 8;
    localparam int unsigned CIS_LSB = 6;
    localparam int unsigned MD_LSB = 0;
    localparam int unsigned ST_RUN0_BIT = 4;
    localparam int unsigned ST_RUN3_BIT = 5;
    localparam int unsigned ST_OUT_BIT = 6;
    localparam int unsigned ST_HI_LSB = 8;
    localparam int unsigned COUNT_SLAVE_LSB = 16;

    // --------------------------------------------------------------
    // field encodings
    // --------------------------------------------------------------
    localparam logic [2:0] MD_INTERVAL = 3'h0;
    localparam logic [2:0] MD_ONECOUNT = 3'h4;
    localparam logic [2:0] STS_SOFT = 3'h0;
    localparam logic [2:0] STS_EDGE = 3'h1;
    localparam logic [2:0] STS_BOTH = 3'h2;
    localparam logic [2:0] STS_MASTER = 3'h4;
    localparam logic [1:0] CKS_A = 2'h0;
    localparam logic [1:0] CKS_C = 2'h1;
    localparam logic [1:0] CKS_B = 2'h2;
    localparam logic [1:0] CKS_D = 2'h3;
    localparam logic [1:0] CIS_FALL = 2'h0;
    localparam logic [1:0] CIS_RISE = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [1:0] RST_MASK = 2'h3;

    typedef enum logic {TAPW_IDLE, TAPW_RUN} tapw_run_t;

endpackage : tapw_pkg

// ---- sim/tapw_load_model.sv ----
`timescale 1ns/100ps
module tapw_load_model (
    input wire logic aclk,
    input wire logic pwm_output_pin,
    output int hi_len,
    output int per_len
);
    int hc;
    int pc;
    // measures the load's on-time and the spacing of rising edges
    always @(posedge aclk)
    begin
        pc <= $rose(pwm_output_pin) ? 1 : pc + 1;
        hc <= pwm_output_pin ? hc + 1 : 0;
        if ($rose(pwm_output_pin))
            per_len <= pc;
        if ($fell(pwm_output_pin))
            hi_len <= hc;
    end
endmodule : tapw_load_model

// ---- sim/tapw_top_sva.sv ----
`timescale 1ns/100ps
module tapw_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_output_pin,
    input wire logic master_timer_interrupt,
    input wire logic slave_timer_interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_b_done; s_axi_bvalid && s_axi_bready; endsequence
    a_b_close: assert property (s_b_done |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_r_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
    a_w_block: assert property (s_axi_bvalid |-> !s_axi_wready) else $error("w taken");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
    a_irq0_pulse: assert property (master_timer_interrupt |=> !master_timer_interrupt) else $error("irq0");
    a_irq3_pulse: assert property (slave_timer_interrupt |=> !slave_timer_interrupt) else $error("irq3");
    a_reset_low: assert property ($rose(aresetn) |-> !pwm_output_pin) else $error("pwm at reset");
endmodule : tapw_top_sva

bind tapw_top tapw_top_sva tapw_top_sva_inst (.*);

// ---- sim/tapw_top_tb_top.sv ----
`timescale 1ns/100ps
module tapw_top_tb_top;
    import tapw_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, master_timer_input_pin = 1'b0, slave_timer_input_pin = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_output_pin;
    logic master_timer_interrupt, slave_timer_interrupt;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int num_errors = 0, n_checks = 0, cyc = 0, hi_len, per_len;
    tapw_top tapw_top_inst (.*);
    tapw_load_model tapw_load_model_inst (.*);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk)
        if (++cyc == 3000)
        begin
            num_errors++;
            complete_run();
        end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    // one write (w=1) or one read (w=0); each channel drops valid once taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        do
        begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (w ? !s_axi_bvalid : !s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = w ? s_axi_bresp : s_axi_rresp;
    endtask : bus
    task automatic t_regs;
        bus(1, OFS_MODE0, 32'hD4C1);
        bus(0, OFS_MODE0, 32'h0);
        chk("mode0", 32'hD4C1, rd);
        chk("rd_resp", RESP_OKAY, rsp);
        bus(1, 8'h40, 32'h1);
        chk("bad_wr", RESP_SLVERR, rsp);
        bus(1, OFS_START, 32'h0);
        bus(0, OFS_STATUS, 32'h0);
        chk("start_none", 32'h0, rd & 32'h30F);
        bus(1, OFS_START, 32'hA0F);
        bus(0, OFS_STATUS, 32'h0);
        chk("start_set", 32'h30F, rd & 32'h30F);
        bus(1, OFS_STOP, 32'hF);
    endtask : t_regs
    // master interval timer plus one-count slave, then the load's view
    task automatic run_pwm(input int p, input int r, input int w);
        int n0;
        int n3;
        logic [31:0] held;
        bus(1, OFS_CLKGATE, 32'h1);
        bus(1, OFS_PRESCALE, p);
        bus(1, OFS_MODE0, 32'h0);
        bus(1, OFS_RELOAD, r);
        bus(1, OFS_MODE3, 32'h408);
        bus(1, OFS_WIDTH, w);
        bus(1, OFS_MASK, 32'h0);
        bus(1, OFS_START, 32'h9);
        n0 = 0;
        n3 = 0;
        // both channel events must reach the pins while unmasked
        repeat (60)
        begin
            @(posedge aclk);
            n0 += master_timer_interrupt;
            n3 += slave_timer_interrupt;
        end
        chk("high", w << p, hi_len);
        chk("period", (r + 1) << p, per_len);
        chk("irq_on", 32'h0, (n0 == 0 || n3 == 0) ? 32'h1 : 32'h0);
        bus(1, OFS_MASK, 32'h3);
        n0 = 0;
        repeat (20)
        begin
            @(posedge aclk);
            n0 += master_timer_interrupt;
            n0 += slave_timer_interrupt;
        end
        chk("irq_off", 32'h0, n0);
        // with the unit clock stopped the counters must freeze
        bus(1, OFS_CLKGATE, 32'h0);
        bus(0, OFS_COUNT, 32'h0);
        held = rd;
        repeat (20) @(posedge aclk);
        bus(0, OFS_COUNT, 32'h0);
        chk("gate_hold", held, rd);
    endtask : run_pwm
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        run_pwm(0, 5, 2);
        run_pwm(1, 3, 3);
        complete_run();
    end
endmodule : tapw_top_tb_top
